// ### src/dpscp_pkg.sv
package dpscp_pkg;
  localparam int WORD_W = 24;
  localparam int WIPER_W = 10;
  localparam int NV_DATA_W = 16;
  localparam int NV_WORDS = 16;
  localparam int CNT_W = 5;

  typedef struct packed {
    logic [3:0] command_field;
    logic [3:0] address_field;
    logic [15:0] data_field;
  } dpscp_word_t;

  localparam logic [3:0] CMD_RESTORE = 4'h1;
  localparam logic [3:0] CMD_STORE_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE_DATA = 4'h3;
  localparam logic [3:0] CMD_RESET = 4'h8;
  localparam logic [3:0] CMD_READ_NV = 4'h9;
  localparam logic [3:0] CMD_READ_WIPER = 4'hA;
  localparam logic [3:0] CMD_WRITE_WIPER = 4'hB;
  localparam logic [2:0] GRP_DEC6 = 3'h2;
  localparam logic [2:0] GRP_DEC1 = 3'h3;
  localparam logic [2:0] GRP_INC6 = 3'h6;
  localparam logic [2:0] GRP_INC1 = 3'h7;

  localparam logic [9:0] WIPER_MID = 10'h200;
  localparam logic [9:0] WIPER_MAX = 10'h3FF;
  localparam logic [9:0] WIPER_MIN = 10'h000;
  localparam logic [9:0] WIPER_ONE = 10'h001;
  localparam logic [5:0] WIPER_PAD = 6'h00;
  localparam logic [3:0] NV_ADDR_WIPER = 4'h0;
  localparam logic [3:0] NV_ADDR_LATCH = 4'h1;
  localparam logic [15:0] NV_RST_WIPER = 16'h0200;
  localparam logic [15:0] NV_RST_LATCH = 16'h0003;
  localparam logic [15:0] NV_RST_OTHER = 16'h0000;
  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [4:0] BIT_ZERO = 5'h00;
  localparam logic [4:0] BIT_ONE = 5'h01;
  localparam logic [1:0] QUAD_ZERO = 2'h0;
endpackage

// ### src/dpscp_top.sv
`timescale 1ns/10ps
module dpscp_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  input wire logic cs_n_pin,
  output logic sdo_o,
  output logic sdo_oe_n,
  output logic [dpscp_pkg::WIPER_W-1:0] wiper_setting_register,
  output logic latched_output_first,
  output logic latched_output_second
);
  logic rst_m;
  logic rst_q;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic sclk_d;
  logic cs_d;
  logic [dpscp_pkg::WORD_W-1:0] sreg;
  logic [dpscp_pkg::CNT_W-1:0] bit_cnt;
  logic any_clk;
  logic have_cmd;
  logic po_done;
  logic sdo_bit;
  logic rb_pend;
  logic [dpscp_pkg::NV_DATA_W-1:0] rb_data;
  dpscp_pkg::dpscp_word_t last_word;
  logic [dpscp_pkg::NV_DATA_W-1:0] store [dpscp_pkg::NV_WORDS];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  // Two-stage pin synchronisers: {sclk, sdi, cs_n}
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      sync_a <= 3'h1;
      sync_b <= 3'h1;
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
    end else begin
      sync_a <= {sclk_pin, sdi_pin, cs_n_pin};
      sync_b <= sync_a;
      sclk_d <= sync_b[2];
      cs_d <= sync_b[0];
    end
  end

  wire sclk_s = sync_b[2];
  wire sdi_s = sync_b[1];
  wire cs_s = sync_b[0];
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d & ~cs_s;
  wire cs_rise = cs_s & ~cs_d;
  wire cs_fall = ~cs_s & cs_d;
  wire frame_ok = cs_rise & any_clk & (bit_cnt == dpscp_pkg::BIT_ZERO);
  wire repeat_ok = cs_rise & ~any_clk & have_cmd;
  wire exec = frame_ok | repeat_ok;
  wire misalign = cs_rise & (bit_cnt[1:0] != dpscp_pkg::QUAD_ZERO);
  dpscp_pkg::dpscp_word_t exec_word;
  assign exec_word = frame_ok ? dpscp_pkg::dpscp_word_t'(sreg) : last_word;
  wire [3:0] cmd = exec_word.command_field;
  wire [3:0] addr = exec_word.address_field;
  wire [9:0] wdata = exec_word.data_field[dpscp_pkg::WIPER_W-1:0];
  wire [9:0] nv_wiper = store[dpscp_pkg::NV_ADDR_WIPER][dpscp_pkg::WIPER_W-1:0];
  wire [9:0] w = wiper_setting_register;
  wire [9:0] w_inc1 = (w == dpscp_pkg::WIPER_MAX) ? w : w + dpscp_pkg::WIPER_ONE;
  wire [9:0] w_dec1 = (w == dpscp_pkg::WIPER_MIN) ? w : w - dpscp_pkg::WIPER_ONE;
  wire [9:0] w_inc6 = w[9] ? dpscp_pkg::WIPER_MAX : {w[8:0], 1'b0};
  wire [9:0] w_dec6 = {1'b0, w[9:1]};
  wire is_restore = (cmd == dpscp_pkg::CMD_RESTORE) | (cmd == dpscp_pkg::CMD_RESET);
  wire [9:0] next_wiper =
    (cmd == dpscp_pkg::CMD_WRITE_WIPER) ? wdata :
    is_restore ? nv_wiper :
    (cmd[3:1] == dpscp_pkg::GRP_INC1) ? w_inc1 :
    (cmd[3:1] == dpscp_pkg::GRP_DEC1) ? w_dec1 :
    (cmd[3:1] == dpscp_pkg::GRP_INC6) ? w_inc6 :
    (cmd[3:1] == dpscp_pkg::GRP_DEC6) ? w_dec6 : w;
  wire is_read = (cmd == dpscp_pkg::CMD_READ_NV) | (cmd == dpscp_pkg::CMD_READ_WIPER);
  wire [15:0] next_rb = (cmd == dpscp_pkg::CMD_READ_WIPER) ? {dpscp_pkg::WIPER_PAD, w} :
    store[addr];

  // Frame counting and shift register
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      sreg <= '0;
      bit_cnt <= dpscp_pkg::BIT_ZERO;
      any_clk <= 1'b0;
      sdo_bit <= 1'b1;
    end else begin
      if (sclk_rise) begin
        sreg <= {sreg[dpscp_pkg::WORD_W-2:0], sdi_s};
        bit_cnt <= (bit_cnt == dpscp_pkg::BIT_LAST) ? dpscp_pkg::BIT_ZERO
                   : bit_cnt + dpscp_pkg::BIT_ONE;
        any_clk <= 1'b1;
      end else if (cs_fall && rb_pend) begin
        sreg[dpscp_pkg::NV_DATA_W-1:0] <= rb_data;
        sdo_bit <= sreg[dpscp_pkg::WORD_W-1];
      end else if (cs_fall) begin
        sdo_bit <= sreg[dpscp_pkg::WORD_W-1];
      end else if (cs_rise) begin
        any_clk <= 1'b0;
        if (misalign) begin
          bit_cnt <= dpscp_pkg::BIT_ZERO;
        end
      end
      if (sclk_fall) begin
        sdo_bit <= sreg[dpscp_pkg::WORD_W-1];
      end
    end
  end

  // Open-drain output, released while deselected
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      sdo_o <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_o <= 1'b0;
      sdo_oe_n <= cs_s | sdo_bit;
    end
  end

  // Command execution and readback capture
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      have_cmd <= 1'b0;
      last_word <= '0;
      rb_pend <= 1'b0;
      rb_data <= '0;
    end else if (exec) begin
      have_cmd <= 1'b1;
      last_word <= exec_word;
      rb_pend <= is_read;
      rb_data <= next_rb;
    end else if (cs_fall) begin
      rb_pend <= 1'b0;
    end
  end

  // Wiper and nonvolatile store
  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      po_done <= 1'b0;
      wiper_setting_register <= dpscp_pkg::WIPER_MID;
      for (int i = 0; i < dpscp_pkg::NV_WORDS; i++) begin
        store[i] <= (i == 0) ? dpscp_pkg::NV_RST_WIPER :
                    (i == 1) ? dpscp_pkg::NV_RST_LATCH : dpscp_pkg::NV_RST_OTHER;
      end
    end else if (!po_done) begin
      po_done <= 1'b1;
      wiper_setting_register <= nv_wiper;
    end else if (exec) begin
      wiper_setting_register <= next_wiper;
      if (cmd == dpscp_pkg::CMD_STORE_WIPER) begin
        store[dpscp_pkg::NV_ADDR_WIPER] <= {dpscp_pkg::WIPER_PAD, w};
      end else if (cmd == dpscp_pkg::CMD_STORE_DATA) begin
        store[addr] <= exec_word.data_field;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      latched_output_first <= 1'b1;
      latched_output_second <= 1'b1;
    end else begin
      latched_output_first <= store[dpscp_pkg::NV_ADDR_LATCH][0];
      latched_output_second <= store[dpscp_pkg::NV_ADDR_LATCH][1];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_q);

  property p_release;
    cs_s && $past(cs_s) |-> sdo_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("sdo driven while deselected");

  property p_od;
    sdo_o == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("sdo drives high");

  property p_write;
    po_done && exec && cmd == dpscp_pkg::CMD_WRITE_WIPER |=> w == $past(wdata);
  endproperty
  a_write: assert property (p_write) else $error("wiper write lost");

  property p_only_on_release;
    po_done && $past(po_done) && $changed(w) |-> $past(cs_rise);
  endproperty
  a_only_on_release: assert property (p_only_on_release) else $error("wiper moved mid frame");

  property p_guard;
    misalign |=> bit_cnt == dpscp_pkg::BIT_ZERO;
  endproperty
  a_guard: assert property (p_guard) else $error("misaligned count kept");

  property p_count;
    sclk_rise |=> bit_cnt == (($past(bit_cnt) == dpscp_pkg::BIT_LAST) ? dpscp_pkg::BIT_ZERO
                                : $past(bit_cnt) + dpscp_pkg::BIT_ONE);
  endproperty
  a_count: assert property (p_count) else $error("bit count wrong");

  property p_shift;
    sclk_rise |=> sreg[0] == $past(sdi_s) && sreg[23:1] == $past(sreg[22:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted in msb first");

  property p_sdo_fall;
    sclk_fall |=> ##1 sdo_oe_n == $past(sreg[23], 2);
  endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo not updated on fall");

  sequence s_read_exec;
    po_done && exec && is_read;
  endsequence
  sequence s_next_select;
    ##[1:1000] cs_fall;
  endsequence
  property p_readback;
    s_read_exec |=> rb_pend throughout s_next_select;
  endproperty
  a_readback: assert property (p_readback) else $error("readback dropped");

  property p_preset;
    $rose(po_done) |-> w == nv_wiper;
  endproperty
  a_preset: assert property (p_preset) else $error("power-on preset missing");

  property p_latch;
    ##1 latched_output_first == $past(store[1][0]) && latched_output_second == $past(store[1][1]);
  endproperty
  a_latch: assert property (p_latch) else $error("latched output mismatch");
endmodule

// ### test/dpscp_host_model.sv
`timescale 1ns/10ps
module dpscp_host_model (
  input wire logic mclk,
  input wire logic sdo_line,
  output logic sclk,
  output logic sdi,
  output logic cs_n
);
  logic mode3;

  initial begin
    mode3 = 1'b0;
    sclk = 1'b0;
    sdi = 1'b0;
    cs_n = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Frame of n bits, msb first, sdo sampled before each rise
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] rx);
    rx = '0;
    sclk = mode3;
    gap(2);
    cs_n = 1'b0;
    gap(6);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      sdi = w[i];
      gap(4);
      rx = {rx[46:0], sdo_line};
      sclk = 1'b1;
      gap(4);
    end
    sclk = mode3;
    gap(4);
    cs_n = 1'b1;
    sdi = ~sdi;
    gap(10);
  endtask

  // Select strobe with no clock or data activity
  task automatic pulse();
    cs_n = 1'b0;
    gap(6);
    cs_n = 1'b1;
    gap(10);
  endtask
endmodule

// ### test/digipot_serial_command_port_tb.sv
`timescale 1ns/10ps
module digipot_serial_command_port_tb;
  logic mclk;
  logic rst_n;
  wire sclk;
  wire sdi;
  wire cs_n;
  logic sdo_o;
  logic sdo_oe_n;
  logic [9:0] wiper;
  logic lo1;
  logic lo2;
  logic [47:0] rx;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // Pull-up on the open-drain line
  wire sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

  dpscp_top dut_u (.mclk(mclk), .rst_n(rst_n), .sclk_pin(sclk), .sdi_pin(sdi),
    .cs_n_pin(cs_n), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .wiper_setting_register(wiper),
    .latched_output_first(lo1), .latched_output_second(lo2));
  dpscp_host_model host_u (.mclk(mclk), .sdo_line(sdo_line), .sclk(sclk), .sdi(sdi),
    .cs_n(cs_n));

  function automatic dpscp_pkg::dpscp_word_t mkw(input logic [3:0] c, input logic [3:0] a,
    input logic [15:0] d);
    return {c, a, d};
  endfunction

  function automatic logic [23:0] wz(input logic [9:0] x);
    return {14'h0000, x};
  endfunction

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic x24(input logic [23:0] w);
    host_u.xfer({24'h000000, w}, 24, rx);
  endtask

  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk("wiper_reset", wz(wiper), 24'h000200);
    chk("latched_reset", {22'h000000, lo2, lo1}, 24'h000003);
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    dpscp_pkg::dpscp_word_t w;
    dpscp_pkg::dpscp_word_t prev;
    logic [15:0] d;
    void'($urandom(63));
    reset_dut();
    host_u.pulse();
    chk("no_repeat", wz(wiper), 24'h000200);
    prev = '0;
    // Random wiper writes in both modes, chained output checked
    for (int k = 0; k < 8; k++) begin
      host_u.mode3 = k[0];
      w = mkw(4'hB, 4'h0, 16'($urandom));
      if (k == 7) w.data_field = 16'hFFFF;
      x24(w);
      if (k > 0) chk("chain", rx[23:0], prev);
      chk("wiper", wz(wiper), wz(w.data_field[9:0]));
      chk("released", {23'h000000, sdo_oe_n}, 24'h000001);
      prev = w;
    end
    d = 16'($urandom);
    host_u.xfer({mkw(4'hB, 4'h0, ~d), mkw(4'h0, 4'h0, d)}, 48, rx);
    chk("chain48", rx[47:24], prev);
    chk("wiper48", wz(wiper), wz(prev.data_field[9:0]));
    host_u.xfer({mkw(4'h0, 4'h0, d), mkw(4'hB, 4'h0, 16'h01FE)}, 48, rx);
    chk("pass48", rx[23:0], mkw(4'h0, 4'h0, d));
    chk("wiper48b", wz(wiper), 24'h0001FE);
    x24(mkw(4'hE, 4'h0, d));
    chk("incr", wz(wiper), 24'h0001FF);
    host_u.pulse();
    chk("repeat", wz(wiper), 24'h000200);
    host_u.xfer({24'h000000, mkw(4'hB, 4'h0, 16'h0155)}, 5, rx);
    chk("odd_count", wz(wiper), 24'h000200);
    x24(mkw(4'hB, 4'h0, 16'h0155));
    chk("realigned", wz(wiper), 24'h000155);
    x24(mkw(4'hA, 4'h0, d));
    x24(mkw(4'h0, 4'h0, d));
    chk("read_wiper", rx[23:0], 24'hA00155);
    x24(mkw(4'h3, 4'h5, d));
    x24(mkw(4'h9, 4'h5, ~d));
    x24(mkw(4'h0, 4'h0, d));
    chk("read_store", rx[23:0], {8'h95, d});
    x24(mkw(4'h2, 4'h0, d));
    x24(mkw(4'hC, 4'h0, d));
    chk("double", wz(wiper), 24'h0002AA);
    x24(mkw(4'hD, 4'h0, d));
    chk("double_sat", wz(wiper), 24'h0003FF);
    x24(mkw(4'h5, 4'h0, d));
    chk("halve", wz(wiper), 24'h0001FF);
    x24(mkw(4'h6, 4'h0, d));
    chk("decr", wz(wiper), 24'h0001FE);
    x24(mkw(4'h1, 4'h0, d));
    chk("restore", wz(wiper), 24'h000155);
    x24(mkw(4'hB, 4'h0, 16'h0000));
    x24(mkw(4'h7, 4'h0, d));
    chk("decr_sat", wz(wiper), 24'h000000);
    x24(mkw(4'h8, 4'h0, d));
    chk("reset_cmd", wz(wiper), 24'h000155);
    host_u.xfer({44'h00000000000, 4'hB}, 4, rx);
    chk("split_hold", wz(wiper), 24'h000155);
    host_u.xfer({28'h0000000, 20'h000AB}, 20, rx);
    chk("split_exec", wz(wiper), 24'h0000AB);
    x24(mkw(4'h3, dpscp_pkg::NV_ADDR_LATCH, 16'h0002));
    chk("latched", {22'h000000, lo2, lo1}, 24'h000002);
    reset_dut();
    conclude();
  end
endmodule
